// ### src/cdp_pkg.sv
/*
  Shared constants for the 4-bit CPU datapath: register offsets, command
  field layout, operation codes, reset values and machine-cycle timing.
  Assumes a 32-bit APB master and a 10 MHz system clock.
*/
package cdp_pkg;

  // APB register byte offsets
  localparam logic [7:0] CMD_OFS   = 8'h00;  // Command write, busy read
  localparam logic [7:0] ACC_OFS   = 8'h04;  // Accumulator and flags
  localparam logic [7:0] TMP_OFS   = 8'h08;  // Registers B, E, D
  localparam logic [7:0] PC_OFS    = 8'h0C;  // Program counter and depth
  localparam logic [7:0] DP_OFS    = 8'h10;  // Data pointer and skip flag

  // Command word fields
  localparam int OP_LSB  = 0;   // Operation code, 5 bits
  localparam int IMM_LSB = 8;   // Immediate, 14 bits
  localparam int BIT_LSB = 24;  // Bit index, 2 bits

  // Status field positions
  localparam int ACC_CY_POS   = 4;   // Carry flag
  localparam int ACC_SKIP_POS = 5;   // Skip flag
  localparam int ACC_UPT_POS  = 6;   // Upper-reference flag
  localparam int TMP_E_LSB    = 4;   // Register E
  localparam int TMP_D_LSB    = 12;  // Register D
  localparam int PC_SP_LSB    = 16;  // Stack depth pointer
  localparam int DP_SKIP_POS  = 16;  // Skip flag in data pointer reg

  // Sizes
  localparam int PC_W    = 14;  // Program counter width
  localparam int PCL_W   = 7;   // In-page field width
  localparam int DP_W    = 10;  // Data pointer width
  localparam int STK_DEP = 8;   // Return stack depth
  localparam int SP_W    = 3;   // Stack pointer width

  // Timing: system clock divided by three per machine cycle
  localparam int          CLK_NS      = 100;
  localparam int          MCYC_NS     = 300;
  localparam logic [1:0]  MCYC_CNT    = 2'((MCYC_NS + CLK_NS - 1) / CLK_NS);

  // Reset values
  localparam logic [PC_W-1:0] PC_RST = 14'h0000;
  localparam logic [3:0]      NIB_RST = 4'h0;

  // Datapath operations
  typedef enum logic [4:0] {
    OP_NOP      = 5'h00, OP_LDI      = 5'h01, OP_ADDI     = 5'h02,
    OP_ADDM     = 5'h03, OP_ADDMC    = 5'h04, OP_ANDM     = 5'h05,
    OP_ORM      = 5'h06, OP_CMPM     = 5'h07, OP_SETB     = 5'h08,
    OP_CLRB     = 5'h09, OP_RAR      = 5'h0A, OP_SETC     = 5'h0B,
    OP_CLRC     = 5'h0C, OP_TBA      = 5'h0D, OP_TAB      = 5'h0E,
    OP_XAB      = 5'h0F, OP_TEAB     = 5'h10, OP_TABE     = 5'h11,
    OP_TDA      = 5'h12, OP_SET_UPPER_REF_OP     = 5'h13, OP_CLEAR_UPPER_REF_OP     = 5'h14,
    OP_TABP     = 5'h15, OP_BLA      = 5'h16, OP_BMLA     = 5'h17,
    OP_CALL     = 5'h18, OP_RET      = 5'h19, OP_INT      = 5'h1A,
    OP_RETI     = 5'h1B, OP_COPY_DEPTH_TO_ACC_OP     = 5'h1C, OP_JMP      = 5'h1D
  } cdp_op_t;

  // Arithmetic unit functions
  typedef enum logic [2:0] {
    ALU_ADD = 3'b000, ALU_ADC = 3'b001, ALU_AND = 3'b010,
    ALU_OR  = 3'b011, ALU_SET = 3'b100, ALU_CLR = 3'b101
  } cdp_alu_t;

endpackage : cdp_pkg

// ### src/cdp_alu.sv
/*
  4-bit arithmetic unit: add, add with carry, AND, OR, bit set/clear,
  and equality compare. Purely combinational.
  Assumes operands are stable for the machine cycle that uses them.
*/
`timescale 1ns/1ps
`default_nettype none
module cdp_alu
  import cdp_pkg::*;
(
  input  wire logic     [3:0] a_in,
  input  wire logic     [3:0] m_in,
  input  wire logic           cy_in,
  input  wire logic     [1:0] bit_sel,
  input  wire cdp_alu_t       func,
  output logic          [3:0] result,
  output logic                carry_out,
  output logic                equal
);

  logic [4:0] sum;  // Sum with carry

  // Function select
  always_comb begin
    sum       = 5'(a_in) + 5'(m_in) + ((func == ALU_ADC) ? 5'(cy_in) : 5'h00);
    result    = sum[3:0];
    carry_out = sum[4];
    equal     = (a_in == m_in);
    unique case (func)
      ALU_ADD, ALU_ADC: result = sum[3:0];
      ALU_AND:          result = a_in & m_in;
      ALU_OR:           result = a_in | m_in;
      ALU_SET:          result = m_in | (4'h1 << bit_sel);
      ALU_CLR:          result = m_in & ~(4'h1 << bit_sel);
      default:          result = sum[3:0];
    endcase
  end

endmodule : cdp_alu
`default_nettype wire

// ### src/cdp_stack.sv
/*
  Eight-entry program-counter return stack with a 3-bit depth pointer.
  Push past eight wraps and overwrites the oldest entries.
  Assumes push and pop are never asserted together.
*/
`timescale 1ns/1ps
`default_nettype none
module cdp_stack
  import cdp_pkg::*;
#(
  parameter int DEPTH = STK_DEP,
  parameter int WIDTH = PC_W
)(
  input  wire logic             mclk,
  input  wire logic             rst,
  input  wire logic             push,
  input  wire logic             pop,
  input  wire logic [WIDTH-1:0] push_data,
  output logic      [WIDTH-1:0] top_data,
  output logic      [SP_W-1:0]  sp
);

  logic [WIDTH-1:0] entry_reg [DEPTH];  // Saved return addresses
  logic [SP_W-1:0]  sp_reg;             // Next free slot

  // Depth pointer; wraps so a ninth push overwrites slot zero
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      sp_reg <= '0;
    end else if (push) begin
      sp_reg <= sp_reg + 3'h1;
    end else if (pop) begin
      sp_reg <= sp_reg - 3'h1;
    end
  end

  // Storage, written at the free slot
  always_ff @(posedge mclk) begin
    if (push) begin
      entry_reg[sp_reg] <= push_data;
    end
  end

  assign top_data = entry_reg[sp_reg - 3'h1];
  assign sp       = sp_reg;

endmodule : cdp_stack
`default_nettype wire

// ### src/cdp_core.sv
/*
  4-bit CPU register datapath: accumulator, carry, B, E, D, upper-reference
  flag, program counter, return stack and interrupt context register.
  Commands arrive over APB and run one per machine cycle (three clocks).
  Assumes RAM read data and ROM data are valid by the next machine cycle.
*/
`timescale 1ns/1ps
`default_nettype none
module cdp_core
  import cdp_pkg::*;
(
  input  wire logic                      mclk,
  input  wire logic                      rst,
  input  wire logic                      psel,
  input  wire logic                      penable,
  input  wire logic                      pwrite,
  input  wire logic [7:0]                paddr,
  input  wire logic [31:0]               pwdata,
  output logic                           pready,
  output logic      [31:0]               prdata,
  output logic                           pslverr,
  input  wire logic [3:0]                ram_rdata,
  input  wire logic [9:0]                rom_rdata,
  output logic      [cdp_pkg::PC_W-1:0]  rom_addr,
  output logic      [3:0]                ram_wdata,
  output logic                           ram_we
);
  import cdp_pkg::*;

  //////////////////////////////////////////////////////////////////////////
  // Declarations

  logic [1:0]      phase_reg;      // Machine-cycle phase counter
  logic            tick;           // Last clock of a machine cycle
  logic            pend_reg;       // Command waiting for a tick
  logic [31:0]     cmd_reg;        // Latched command word
  logic            tab_wait_reg;   // Table lookup awaiting ROM data
  logic [3:0]      acc_reg;        // Accumulator
  logic            cy_reg;         // Carry flag
  logic [3:0]      b_reg;          // Register B
  logic [7:0]      e_reg;          // Register E
  logic [2:0]      d_reg;          // Register D
  logic            upt_reg;        // Upper-reference select flag
  logic            skip_reg;       // Skip flag
  logic [DP_W-1:0] dp_reg;         // Data pointer
  logic [PC_W-1:0] pc_reg;         // Program counter
  logic [DP_W-1:0] ctx_dp_reg;     // Interrupt context: data pointer
  logic            ctx_cy_reg;     // Interrupt context: carry
  logic            ctx_skip_reg;   // Interrupt context: skip
  logic [3:0]      ctx_a_reg;      // Interrupt context: accumulator
  logic [3:0]      ctx_b_reg;      // Interrupt context: B
  logic            acc_we;         // APB access phase with ready
  logic            wr_en;          // Write takes effect
  cdp_op_t         op;             // Decoded operation
  logic [13:0]     imm;            // Immediate field
  logic            run;            // Execute op this clock
  cdp_alu_t        alu_func;       // Arithmetic function
  logic [3:0]      alu_res;        // Arithmetic result
  logic            alu_cy;         // Arithmetic carry out
  logic            alu_eq;         // Compare result
  logic            st_push;        // Stack push
  logic            st_pop;         // Stack pop
  logic [PC_W-1:0] st_top;         // Most recent return address
  logic [SP_W-1:0] sp;             // Stack depth

  // Next program counter with in-page rollover into the next page
  function automatic logic [PC_W-1:0] pc_inc(input logic [PC_W-1:0] p);
    logic [PCL_W-1:0]      low;
    logic [PC_W-PCL_W-1:0] page;
    low  = p[PCL_W-1:0];
    page = p[PC_W-1:PCL_W];
    if (low == 7'h7F) begin
      return {page + 7'h01, 7'h00};
    end
    return {page, low + 7'h01};
  endfunction : pc_inc

  // Page-relative target from D and A
  function automatic logic [PC_W-1:0] page_ptr(input logic [6:0] page,
                                               input logic [2:0] d,
                                               input logic [3:0] a);
    return {page, d, a};
  endfunction : page_ptr

  //////////////////////////////////////////////////////////////////////////
  // Machine-cycle timing

  // Divide by three; commands only run on the final clock
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      phase_reg <= 2'h0;
    end else if (phase_reg == MCYC_CNT - 2'h1) begin
      phase_reg <= 2'h0;
    end else begin
      phase_reg <= phase_reg + 2'h1;
    end
  end

  assign tick = (phase_reg == MCYC_CNT - 2'h1);

  //////////////////////////////////////////////////////////////////////////
  // APB slave: one wait state, ready and data registered

  assign acc_we = psel & penable & pready;
  assign wr_en  = acc_we & pwrite;

  // Ready pulse in the second access cycle
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      pready <= 1'b0;
    end else begin
      pready <= psel & penable & ~pready;
    end
  end

  // Read mux and unmapped-address error
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (psel & penable & ~pready) begin
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
      unique case (paddr)
        CMD_OFS: prdata <= {30'h0, tab_wait_reg, pend_reg};
        ACC_OFS: prdata <= {25'h0, upt_reg, skip_reg, cy_reg, acc_reg};
        TMP_OFS: prdata <= {17'h0, d_reg, e_reg, b_reg};
        PC_OFS:  prdata <= {13'h0, sp, 2'h0, pc_reg};
        DP_OFS:  prdata <= {15'h0, skip_reg, 6'h0, dp_reg};
        default: pslverr <= 1'b1;
      endcase
    end else begin
      pslverr <= 1'b0;
    end
  end

  // Command latch; a new command while busy is dropped
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      pend_reg <= 1'b0;
      cmd_reg  <= 32'h0000_0000;
    end else if (wr_en && paddr == CMD_OFS && !pend_reg && !tab_wait_reg) begin
      pend_reg <= 1'b1;
      cmd_reg  <= pwdata;
    end else if (run) begin
      pend_reg <= 1'b0;
    end
  end

  assign op   = cdp_op_t'(cmd_reg[OP_LSB +: 5]);
  assign imm  = cmd_reg[IMM_LSB +: 14];
  assign run  = tick & pend_reg & ~tab_wait_reg;

  //////////////////////////////////////////////////////////////////////////
  // Arithmetic unit and return stack

  // Pick the arithmetic function for the current op
  always_comb begin
    unique case (op)
      OP_ADDMC: alu_func = ALU_ADC;
      OP_ANDM:  alu_func = ALU_AND;
      OP_ORM:   alu_func = ALU_OR;
      OP_SETB:  alu_func = ALU_SET;
      OP_CLRB:  alu_func = ALU_CLR;
      default:  alu_func = ALU_ADD;
    endcase
  end

  cdp_alu u_alu (
    .a_in      (acc_reg),
    .m_in      ((op == OP_ADDI) ? imm[3:0] : ram_rdata),
    .cy_in     (cy_reg),
    .bit_sel   (cmd_reg[BIT_LSB +: 2]),
    .func      (alu_func),
    .result    (alu_res),
    .carry_out (alu_cy),
    .equal     (alu_eq)
  );

  // Calls, lookups and interrupt entry all share the stack
  assign st_push = run & (op == OP_CALL || op == OP_BMLA ||
                          op == OP_TABP || op == OP_INT);
  assign st_pop  = (run & (op == OP_RET || op == OP_RETI)) |
                   (tick & tab_wait_reg);

  cdp_stack u_stack (
    .mclk      (mclk),
    .rst       (rst),
    .push      (st_push),
    .pop       (st_pop),
    .push_data (pc_inc(pc_reg)),
    .top_data  (st_top),
    .sp        (sp)
  );

  //////////////////////////////////////////////////////////////////////////
  // Accumulator and B

  // Accumulator is the common destination
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      acc_reg <= NIB_RST;
    end else if (tick & tab_wait_reg) begin
      acc_reg <= rom_rdata[3:0];
    end else if (run) begin
      unique case (op)
        OP_LDI:                    acc_reg <= imm[3:0];
        OP_ADDI, OP_ADDM, OP_ADDMC,
        OP_ANDM, OP_ORM:           acc_reg <= alu_res;
        OP_RAR:                    acc_reg <= {cy_reg, acc_reg[3:1]};
        OP_TAB, OP_XAB:            acc_reg <= b_reg;
        OP_TEAB:                   acc_reg <= e_reg[3:0];
        OP_COPY_DEPTH_TO_ACC_OP:                   acc_reg <= {1'b0, sp};
        OP_RETI:                   acc_reg <= ctx_a_reg;
        default:                   acc_reg <= acc_reg;
      endcase
    end
  end

  // B holds temporaries and the high nibble of pairs
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      b_reg <= NIB_RST;
    end else if (tick & tab_wait_reg) begin
      b_reg <= rom_rdata[7:4];
    end else if (run) begin
      unique case (op)
        OP_TBA, OP_XAB: b_reg <= acc_reg;
        OP_TEAB:        b_reg <= e_reg[7:4];
        OP_RETI:        b_reg <= ctx_b_reg;
        default:        b_reg <= b_reg;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Carry and skip flags

  // Carry changes only on add-with-carry, rotate, set, clear, interrupt return
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      cy_reg <= 1'b0;
    end else if (run) begin
      unique case (op)
        OP_ADDMC: cy_reg <= alu_cy;
        OP_RAR:   cy_reg <= acc_reg[0];
        OP_SETC:  cy_reg <= 1'b1;
        OP_CLRC:  cy_reg <= 1'b0;
        OP_RETI:  cy_reg <= ctx_cy_reg;
        default:  cy_reg <= cy_reg;
      endcase
    end
  end

  // Skip flag: compare sets it, software may also write it
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      skip_reg <= 1'b0;
    end else if (run && op == OP_CMPM) begin
      skip_reg <= alu_eq;
    end else if (run && op == OP_RETI) begin
      skip_reg <= ctx_skip_reg;
    end else if (wr_en && paddr == DP_OFS) begin
      skip_reg <= pwdata[DP_SKIP_POS];
    end
  end

  // Data pointer, written by software, restored on interrupt return
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      dp_reg <= '0;
    end else if (run && op == OP_RETI) begin
      dp_reg <= ctx_dp_reg;
    end else if (wr_en && paddr == DP_OFS) begin
      dp_reg <= pwdata[DP_W-1:0];
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Registers E, D and upper-reference flag

  // E has no reset; software must load it first
  always_ff @(posedge mclk) begin
    if (run && op == OP_TABE) begin
      e_reg <= {b_reg, acc_reg};
    end
  end

  // D has no reset; loaded from A or from lookup data
  always_ff @(posedge mclk) begin
    if (run && op == OP_TDA) begin
      d_reg <= acc_reg[2:0];
    end else if (tick && tab_wait_reg && upt_reg) begin
      d_reg <= {1'b0, rom_rdata[9:8]};
    end
  end

  // Upper-reference flag
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      upt_reg <= 1'b0;
    end else if (run && op == OP_SET_UPPER_REF_OP) begin
      upt_reg <= 1'b1;
    end else if (run && op == OP_CLEAR_UPPER_REF_OP) begin
      upt_reg <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Interrupt context register

  // Written only on interrupt entry; calls and lookups leave it alone
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      ctx_dp_reg   <= '0;
      ctx_cy_reg   <= 1'b0;
      ctx_skip_reg <= 1'b0;
      ctx_a_reg    <= NIB_RST;
      ctx_b_reg    <= NIB_RST;
    end else if (run && op == OP_INT) begin
      ctx_dp_reg   <= dp_reg;
      ctx_cy_reg   <= cy_reg;
      ctx_skip_reg <= skip_reg;
      ctx_a_reg    <= acc_reg;
      ctx_b_reg    <= b_reg;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Program counter and table lookup

  // Lookup: push and fetch, then pop and load on the next machine cycle
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      tab_wait_reg <= 1'b0;
    end else if (run && op == OP_TABP) begin
      tab_wait_reg <= 1'b1;
    end else if (tick) begin
      tab_wait_reg <= 1'b0;
    end
  end

  // PC steps once per executed command; jumps, calls, returns and lookups load it instead
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      pc_reg <= PC_RST;
    end else if (tick & tab_wait_reg) begin
      pc_reg <= st_top;
    end else if (run) begin
      unique case (op)
        OP_BLA, OP_BMLA:   pc_reg <= page_ptr(imm[6:0], d_reg, acc_reg);
        OP_CALL, OP_INT,
        OP_JMP:            pc_reg <= imm;
        OP_RET, OP_RETI:   pc_reg <= st_top;
        OP_TABP:           pc_reg <= pc_reg;
        default:           pc_reg <= pc_inc(pc_reg);
      endcase
    end
  end

  // ROM address: lookup pointer while fetching, else PC
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      rom_addr <= PC_RST;
    end else if (run && op == OP_TABP) begin
      rom_addr <= page_ptr(imm[6:0], d_reg, acc_reg);
    end else if (tick && !tab_wait_reg) begin
      rom_addr <= pc_reg;  // Machine-cycle boundaries only: one ROM address per cycle
    end
  end

  // RAM write-back for bit manipulation
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      ram_wdata <= NIB_RST;
      ram_we    <= 1'b0;
    end else begin
      ram_we <= run & (op == OP_SETB || op == OP_CLRB);
      if (run && (op == OP_SETB || op == OP_CLRB)) begin
        ram_wdata <= alu_res;
      end
    end
  end

endmodule : cdp_core
`default_nettype wire

// ### sim/cdp_core_props.sv
/* Port checker for cdp_core.
   Assumes one clock and an asynchronous active-high reset. */
`timescale 1ns/1ps
`default_nettype none
module cdp_core_props
  import cdp_pkg::*;
(
  input wire logic            mclk,
  input wire logic            rst,
  input wire logic            psel,
  input wire logic            penable,
  input wire logic            pwrite,
  input wire logic [7:0]      paddr,
  input wire logic [31:0]     pwdata,
  input wire logic            pready,
  input wire logic [31:0]     prdata,
  input wire logic            pslverr,
  input wire logic [3:0]      ram_rdata,
  input wire logic [9:0]      rom_rdata,
  input wire logic [PC_W-1:0] rom_addr,
  input wire logic [3:0]      ram_wdata,
  input wire logic            ram_we
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  ////////////////////////////////////////////////////////////////
  chk_one_wait: assert property ($rose(penable) && psel |=> pready)
    else $error("ready not after one wait");
  chk_rdy_phase: assert property (pready |-> psel && penable)
    else $error("ready outside access");
  chk_rdy_pulse: assert property (pready |=> !pready)
    else $error("ready too long");
  chk_err_zero: assert property (pslverr |-> pready && prdata == 32'h0)
    else $error("error data not zero");
  chk_acc_upper: assert property (pready && !pwrite && paddr == ACC_OFS |-> prdata[31:7] == 25'h0)
    else $error("accumulator word too wide");
  chk_pc_upper: assert property (pready && !pwrite && paddr == PC_OFS |-> prdata[31:19] == 13'h0)
    else $error("depth field too wide");
  chk_pc_start: assert property ($fell(rst) |-> rom_addr == PC_RST && !ram_we)
    else $error("start address wrong");
  chk_we_cycle: assert property (ram_we |=> !ram_we [*2])
    else $error("write faster than machine cycle");
  chk_pc_cycle: assert property (!$stable(rom_addr) |=> $stable(rom_addr) [*2])
    else $error("address faster than machine cycle");
  // Main scenarios reached
  cov_err: cover property (pslverr);
  cov_we: cover property (ram_we);
  cov_pc: cover property (!$stable(rom_addr));
endmodule : cdp_core_props
bind cdp_core cdp_core_props chk_u (.mclk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
  .prdata, .pslverr, .ram_rdata, .rom_rdata, .rom_addr, .ram_wdata, .ram_we);
`default_nettype wire

// ### sim/cdp_mem_model.sv
/* ROM and one RAM nibble on the far side of cdp_core.
   Assumes the bench preloads the nibble between commands. */
`timescale 1ns/1ps
`default_nettype none
module cdp_mem_model (
  input  wire logic        mclk,
  input  wire logic        rst,
  input  wire logic [13:0] rom_addr,
  input  wire logic        ram_we,
  input  wire logic [3:0]  ram_wdata,
  input  wire logic        ld,
  input  wire logic [3:0]  ld_val,
  output logic      [3:0]  ram_rdata,
  output logic      [9:0]  rom_rdata
);
  // Fixed scramble of the low ten address bits; table words repeat every 1024 addresses
  assign rom_rdata = rom_addr[9:0] ^ 10'h2A5;
  // Bit ops write back; bench preload otherwise
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) ram_rdata <= 4'h0;
    else if (ram_we) ram_rdata <= ram_wdata;
    else if (ld) ram_rdata <= ld_val;
  end
endmodule : cdp_mem_model
`default_nettype wire

// ### sim/cdp_core_tb.sv
/* Self-checking bench for cdp_core against an integer model.
   Assumes cdp_mem_model as ROM and RAM. */
`timescale 1ns/1ps
`default_nettype none
module cdp_core_tb;
  import cdp_pkg::*;
  logic        mclk, rst, psel, penable, pwrite, pready, pslverr, ram_we, ld, er;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rnd, r;
  logic [3:0]  ram_rdata, ram_wdata, ld_val;
  logic [9:0]  rom_rdata;
  logic [13:0] rom_addr;
  int          n_errors, n_compared, ed, a, b, cy, sk, up, e, d, pc, sp, m, ca, cb, cc, cs, t, dv, cd;
  int          stk [8];
  logic [4:0]  ops [16] = '{5'h02, 5'h03, 5'h04, 5'h05, 5'h06, 5'h08, 5'h09, 5'h0A,
                            5'h0B, 5'h0C, 5'h0F, 5'h10, 5'h11, 5'h13, 5'h14, 5'h15};
  cdp_core dut_u (.mclk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .prdata,
    .pslverr, .ram_rdata, .rom_rdata, .rom_addr, .ram_wdata, .ram_we);
  cdp_mem_model mem_u (.mclk, .rst, .rom_addr, .ram_we, .ram_wdata, .ld, .ld_val, .ram_rdata, .rom_rdata);
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask : cmp
  // Hold the request until ready is seen high
  // No cycle count is assumed; only the watchdog ends a hung wait
  task automatic apb(input logic wr, input logic [7:0] ad, input logic [31:0] wd);
    psel <= 1'b1; pwrite <= wr; paddr <= ad; pwdata <= wd;
    @(posedge mclk);
    penable <= 1'b1;
    do @(posedge mclk); while (pready !== 1'b1);
    r = prdata; er = pslverr;
    psel <= 1'b0; penable <= 1'b0;
    @(posedge mclk);
  endtask : apb
  task automatic rchk(input logic [7:0] ad, input logic [31:0] exp);
    apb(1'b0, ad, 32'h0);
    cmp(r, exp);
  endtask : rchk
  // Issue, wait for idle, step the model, compare state
  task automatic cmd(input logic [4:0] op, input logic [13:0] im, input logic [1:0] bi);
    apb(1'b1, CMD_OFS, {6'h0, bi, 2'h0, im, 3'h0, op});
    do apb(1'b0, CMD_OFS, 32'h0); while (r[1:0] !== 2'b00);
    pc = (pc + 1) % 16384; t = a + m;
    case (int'(op))
      1: a = im % 16;
      2: a = (a + im) % 16;
      3: a = t % 16;
      4: begin t = t + cy; a = t % 16; cy = t / 16; end
      5: a = a & m;
      6: a = a | m;
      7: sk = (a == m);
      8: m = m | (1 << bi);
      9: m = m & ~(1 << bi);
      10: begin t = cy; cy = a % 2; a = a / 2 + 8 * t; end
      11: cy = 1;
      12: cy = 0;
      13: b = a;
      14: a = b;
      15: begin t = a; a = b; b = t; end
      16: begin a = e % 16; b = e / 16; end
      17: e = b * 16 + a;
      18: d = a % 8;
      19: up = 1;
      20: up = 0;
      21: begin stk[sp] = pc; t = ((im % 128) * 128 + d * 16 + a) % 1024 ^ 'h2A5;
        a = t % 16; b = t / 16 % 16; if (up) d = t / 256; end
      22, 23: begin if (op == 5'h17) begin stk[sp] = pc; sp = (sp + 1) % 8; end
        pc = (im % 128) * 128 + d * 16 + a; end
      24, 26: begin stk[sp] = pc; sp = (sp + 1) % 8; pc = im;
        if (op == 5'h1A) begin cc = cy; cs = sk; ca = a; cb = b; cd = dv; end end
      25, 27: begin sp = (sp + 7) % 8; pc = stk[sp];
        if (op == 5'h1B) begin cy = cc; sk = cs; a = ca; b = cb; dv = cd; end end
      28: a = sp;
      29: pc = im;
      default: ;
    endcase
    rchk(ACC_OFS, {25'h0, 1'(up), 1'(sk), 1'(cy), 4'(a)});
    if (ed == 1) rchk(TMP_OFS, {17'h0, 3'(d), 8'(e), 4'(b)});
    rchk(PC_OFS, {13'h0, 3'(sp), 2'h0, 14'(pc)});
    // Bit-op write-back reaches the RAM nibble
    if (op == 5'h08 || op == 5'h09) cmp(32'(ram_rdata), 32'(m));
  endtask : cmd
  task automatic wrap_up;
    $display("compared %0d errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : wrap_up
  // Watchdog well beyond the expected run
  initial begin
    #3000000;
    n_errors++;
    wrap_up();
  end
  initial begin
    {rst, psel, penable, pwrite, ld} = 5'b10000;
    paddr = 8'h00; pwdata = 32'h0; ld_val = 4'h0; rnd = 32'hAF51;
    repeat (3) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    rchk(ACC_OFS, 32'h0);
    rchk(PC_OFS, 32'h0);
    apb(1'b0, 8'h14, 32'h0);
    cmp({31'h0, er}, 32'h1);
    cmd(5'h01, 14'h5, 2'h0);
    cmd(5'h12, 14'h0, 2'h0);
    cmd(5'h11, 14'h0, 2'h0);
    ed = 1;
    for (int i = 0; i < 40; i++) begin
      rnd = lfsr(rnd);
      ld <= 1'b1; ld_val <= rnd[3:0]; m = rnd[3:0];
      @(posedge mclk);
      ld <= 1'b0;
      cmd(ops[rnd[7:4]], {10'h0, rnd[11:8]}, rnd[13:12]);
    end
    cmd(5'h13, 14'h0, 2'h0);
    cmd(5'h15, 14'h15, 2'h0);
    cmd(5'h14, 14'h0, 2'h0);
    cmd(5'h15, 14'h2A, 2'h0);
    cmd(5'h0D, 14'h0, 2'h0);
    cmd(5'h0E, 14'h0, 2'h0);
    apb(1'b1, DP_OFS, 32'h0001_0155);
    sk = 1;
    dv = 'h155;
    cmd(5'h1A, 14'h80, 2'h0);
    apb(1'b1, DP_OFS, 32'h0000_02AA);
    sk = 0;
    dv = 'h2AA;
    cmd(5'h01, 14'h9, 2'h0);
    cmd(5'h0F, 14'h0, 2'h0);
    cmd(5'h18, 14'h100, 2'h0);
    cmd(5'h19, 14'h0, 2'h0);
    cmd(5'h1B, 14'h0, 2'h0);
    rchk(DP_OFS, {15'h0, 1'(sk), 6'h0, 10'(dv)});
    for (int i = 0; i < 9; i++) cmd(5'h18, 14'(i * 128 + 127), 2'h0);
    cmd(5'h1C, 14'h0, 2'h0);
    for (int i = 0; i < 9; i++) cmd(5'h19, 14'h0, 2'h0);
    cmd(5'h16, 14'h3, 2'h0);
    cmd(5'h17, 14'h5, 2'h0);
    cmd(5'h19, 14'h0, 2'h0);
    cmd(5'h1D, 14'h7F, 2'h0);
    cmd(5'h00, 14'h0, 2'h0);
    cmd(5'h07, 14'h0, 2'h0);
    wrap_up();
  end
endmodule : cdp_core_tb
`default_nettype wire
